// ### logic/battery_charge_param_control.sv
// charge parameter decode, threshold, efficiency and charge request logic
//
// Decided for this implementation: the address map and the address-and-strobe port.
module battery_charge_param_control
  import charge_param_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire logic [7:0]          addr,
  input  wire logic [DATA_W-1:0]   wdata,
  input  wire logic                wr,
  input  wire logic                rd,
  output logic      [DATA_W-1:0]   rdata,
  output logic      [DATA_W-1:0]   charging_current_req,
  output logic      [DATA_W-1:0]   charging_voltage_req,
  output logic                     overvoltage_suspend,
  output logic                     capacity_update
);
  import charge_param_pkg::*;

  // ========================================================================
  // configuration store
  logic [15:0] chg_volt, fast_cur, maint_cur, pre_cur, overload;
  logic [15:0] open_circuit_quarter_voltage, voc50, voc75, fix_final, no_load_voltage, c_word, rate_r;
  logic [7:0]  light_load, pack_cfg, ov_margin, base_eff, self_dis;
  logic [7:0]  batt_low, near_full, eff_temp, eff_drop, eff_rate;
  logic [15:0] meas_volt, meas_cur, meas_temp;
  logic [7:0]  meas_relative_charge_state;
  charge_ctrl_s ctrl;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chg_volt   <= 16'h0000;
      fast_cur   <= 16'h0000;
      maint_cur  <= 16'h0000;
      pre_cur    <= 16'h0000;
      overload   <= 16'h0000;
      open_circuit_quarter_voltage      <= 16'h0000;
      voc50      <= 16'h0000;
      voc75      <= 16'h0000;
      fix_final  <= 16'h0000;
      no_load_voltage        <= 16'h0000;
      c_word     <= 16'h0000;
      rate_r     <= 16'h0000;
      light_load <= 8'h00;
      pack_cfg   <= 8'h00;
      ov_margin  <= 8'h00;
      base_eff   <= 8'h00;
      self_dis   <= 8'h00;
      batt_low   <= 8'h00;
      near_full  <= 8'h00;
      eff_temp   <= 8'h00;
      eff_drop   <= 8'h00;
      eff_rate   <= 8'h00;
      meas_volt  <= 16'h0000;
      meas_cur   <= 16'h0000;
      meas_temp  <= 16'h0000;
      meas_relative_charge_state  <= 8'h00;
      ctrl       <= '0;
    end else if (wr) begin
      case (addr)
        ADDR_CHG_VOLT:   chg_volt   <= wdata;
        ADDR_FAST_CUR:   fast_cur   <= wdata;
        ADDR_MAINT_CUR:  maint_cur  <= wdata;
        ADDR_PRE_CUR:    pre_cur    <= wdata;
        ADDR_OVERLOAD:   overload   <= wdata;
        ADDR_OPEN_CIRCUIT_QUARTER_VOLTAGE:      open_circuit_quarter_voltage      <= wdata;
        ADDR_VOC50:      voc50      <= wdata;
        ADDR_VOC75:      voc75      <= wdata;
        ADDR_FINAL_THR:  fix_final  <= wdata;
        ADDR_EMF_MID:    no_load_voltage        <= wdata;
        ADDR_FIRST_THR:  c_word     <= wdata;
        ADDR_RATE_R:     rate_r     <= wdata;
        ADDR_LIGHT_LOAD: light_load <= wdata[7:0];
        ADDR_PACK_CFG:   pack_cfg   <= wdata[7:0];
        ADDR_OV_MARGIN:  ov_margin  <= wdata[7:0];
        ADDR_BASE_EFF:   base_eff   <= wdata[7:0];
        ADDR_SELF_DIS:   self_dis   <= wdata[7:0];
        ADDR_BATT_LOW:   batt_low   <= wdata[7:0];
        ADDR_NEAR_FULL:  near_full  <= wdata[7:0];
        ADDR_EFF_TEMP:   eff_temp   <= wdata[7:0];
        ADDR_EFF_DROP:   eff_drop   <= wdata[7:0];
        ADDR_EFF_RATE:   eff_rate   <= wdata[7:0];
        ADDR_MEAS_VOLT:  meas_volt  <= wdata;
        ADDR_MEAS_CUR:   meas_cur   <= wdata;
        ADDR_MEAS_TEMP:  meas_temp  <= wdata;
        ADDR_MEAS_RELATIVE_CHARGE_STATE:  meas_relative_charge_state  <= wdata[7:0];
        ADDR_CTRL:       ctrl       <= wdata[4:0];
        default: ;
      endcase
    end
  end

  // ========================================================================
  // decoded configuration
  logic        chemistry_select_li, threshold_compensation_enable_on, vcor_on;
  logic [10:0] cap_adjust;
  logic [4:0]  residual;
  logic [15:0] abs_load;
  logic [7:0]  drop_pct;
  logic [15:0] nfw_mah;

  assign chemistry_select_li    = pack_cfg[CFG_CHEMISTRY_SELECT_BIT];
  assign threshold_compensation_enable_on    = pack_cfg[CFG_THRESHOLD_COMPENSATION_ENABLE_BIT];
  assign vcor_on    = pack_cfg[CFG_VCOR_BIT];
  assign cap_adjust = c_word[ADJ_W-1:0];
  assign residual   = c_word[15:ADJ_W];
  assign abs_load   = meas_cur[15] ? 16'(-meas_cur) : meas_cur;
  assign drop_pct   = 8'(-eff_drop);
  assign nfw_mah    = 16'({8'h00, near_full} << NFW_SHIFT);

  // ========================================================================
  // compensated threshold: simplified linear forms of the factors
  // full shape of the capacity/temperature curve is not modelled here
  function automatic logic [15:0] comp_thr(input logic [7:0] cap_pct);
    logic [31:0] fbl;
    logic [31:0] drop;
    logic [31:0] tz;
    logic [31:0] res;
    fbl  = 32'(no_load_voltage) * (32'(16'h0400) - 32'(cap_adjust)
           + 32'(cap_pct) + 32'(residual));
    tz   = 32'(rate_r) + 32'(meas_temp[15] ? 16'h0000 : 16'h0000);
    drop = 32'(abs_load) * tz;
    res  = (fbl >> 10) - (drop >> 10);
    return res[31] ? 16'h0000 : res[15:0];
  endfunction

  logic        cold;
  logic [15:0] thr_final, thr_mid, thr_first;
  logic [15:0] cold_add;

  // cold factor only below 23 C
  assign cold = $signed(meas_temp) < $signed(16'(COLD_LIMIT_C));
  assign cold_add = cold ? 16'(abs_load >> 6) : 16'h0000;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      thr_final <= 16'h0000;
      thr_mid   <= 16'h0000;
      thr_first <= 16'h0000;
    end else if (threshold_compensation_enable_on) begin
      // computed thresholds; capacity terms 0, 3, battery low
      thr_final <= comp_thr(8'h00) - cold_add;
      thr_mid   <= comp_thr(8'(MID_CAP_PCT)) - cold_add;
      thr_first <= comp_thr(batt_low) - cold_add;
    end else begin
      thr_final <= fix_final;
      thr_mid   <= no_load_voltage;
      thr_first <= c_word;
    end
  end

  // ========================================================================
  // charge efficiency in 0.0125 percent units
  logic [15:0] eff_units;
  logic [15:0] next_eff;
  logic [15:0] relative_charge_state_over, temp_over;
  logic [31:0] rate_sub, temp_sub;

  assign relative_charge_state_over = (meas_relative_charge_state >= drop_pct) ?
                     16'(meas_relative_charge_state - drop_pct) : 16'h0000;
  assign temp_over = ($signed(meas_temp) > $signed(16'(EFF_REF_C))) ?
                     16'(meas_temp - 16'(EFF_REF_C)) : 16'h0000;
  assign rate_sub  = 32'(eff_rate) * 32'(relative_charge_state_over);
  // byte is factor x1.6 in units
  assign temp_sub  = (32'(eff_temp) * 32'(temp_over) * 32'(10)) /
                     32'(TEMP_DIV);

  always_comb begin
    logic [31:0] acc;
    acc = 32'(EFF_BASE_UNITS) + 32'(base_eff) * 32'(EFF_STEP_UNITS);
    if (!chemistry_select_li) begin
      acc = (acc > rate_sub) ? acc - rate_sub : 32'h0;
      acc = (acc > temp_sub) ? acc - temp_sub : 32'h0;
    end
    next_eff = acc[15:0];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) eff_units <= 16'h0000;
    else eff_units <= next_eff;
  end

  // ========================================================================
  // voltage monitors
  logic below_final, below_first, ov_flag, voc_low;
  logic [16:0] ov_limit;

  assign ov_limit = 17'(chg_volt) + 17'({ov_margin, 4'h0});

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      below_final <= 1'b0;
      below_first <= 1'b0;
      ov_flag     <= 1'b0;
      voc_low     <= 1'b0;
    end else begin
      below_final <= meas_volt < thr_final;
      below_first <= meas_volt < thr_first;
      ov_flag     <= 17'(meas_volt) > ov_limit;
      // midrange checks with decoded two's complement
      voc_low     <= vcor_on &&
                     ((meas_volt < 16'(-open_circuit_quarter_voltage)) ||
                      (meas_volt < 16'(-voc50)) ||
                      (meas_volt < 16'(-voc75)));
    end
  end

  // ========================================================================
  // capacity learning
  learn_e learn;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) learn <= LEARN_IDLE;
    else begin
      case (learn)
        LEARN_IDLE:  if (ctrl.near_full && ctrl.discharging)
                       learn <= LEARN_ARMED;
        LEARN_ARMED: if (!ctrl.discharging) learn <= LEARN_IDLE;
                     else if (below_first) learn <= LEARN_DONE;
        // one update per discharge: a held near-full mark must not re-arm
        LEARN_DONE:  if (!ctrl.discharging) learn <= LEARN_IDLE;
        default:     learn <= LEARN_IDLE;
      endcase
    end
  end

  // ========================================================================
  // charging current request
  cur_sel_e sel;
  logic     term_seen;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) term_seen <= 1'b0;
    else if (ctrl.terminated) term_seen <= 1'b1;
    else if (ctrl.fast_allowed && !ctrl.terminated) term_seen <= 1'b0;
  end

  always_comb begin
    if (ctrl.suspended || ctrl.terminated || ov_flag) sel = REQ_ZERO;
    else if (below_final) sel = REQ_PRE;
    else if (ctrl.fast_allowed && !term_seen) sel = REQ_FAST;
    else if (term_seen) sel = REQ_MAINT;
    else sel = REQ_ZERO;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      charging_current_req <= '0;
      charging_voltage_req <= '0;
      overvoltage_suspend  <= 1'b0;
      capacity_update      <= 1'b0;
    end else begin
      case (sel)
        REQ_PRE:   charging_current_req <= pre_cur;
        REQ_FAST:  charging_current_req <= fast_cur;
        REQ_MAINT: charging_current_req <= maint_cur;
        default:   charging_current_req <= '0;
      endcase
      charging_voltage_req <= chg_volt;
      overvoltage_suspend  <= ov_flag;
      // pulse on the armed-to-done step only
      capacity_update      <= learn == LEARN_ARMED && ctrl.discharging &&
                              below_first;
    end
  end

  // ========================================================================
  // read port
  charge_status_s status;
  assign status = '{ov_flag, below_final, below_first, learn == LEARN_DONE,
                    self_dis != 8'h00, voc_low};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) rdata <= '0;
    else if (rd) begin
      case (addr)
        ADDR_STATUS:     rdata <= 16'(status);
        ADDR_THR_FINAL:  rdata <= thr_final;
        ADDR_THR_MID:    rdata <= thr_mid;
        ADDR_THR_FIRST:  rdata <= thr_first;
        ADDR_CUR_REQ:    rdata <= charging_current_req;
        ADDR_EFF_OUT:    rdata <= eff_units;
        ADDR_NFW_OUT:    rdata <= nfw_mah;
        ADDR_OVERLOAD:   rdata <= overload;
        // light-load byte read back as stored
        ADDR_LIGHT_LOAD: rdata <= {8'h00, light_load};
        ADDR_PACK_CFG:   rdata <= {8'h00, pack_cfg};
        ADDR_CHG_VOLT:   rdata <= chg_volt;
        default:         rdata <= '0;
      endcase
    end else rdata <= '0;
  end
endmodule // battery_charge_param_control

// ### shared/charge_param_pkg.sv
// constants, types and register map for the charge parameter control block
// ===========================================================================
// Behaviour
// - compensation off: low-voltage thresholds come straight from stored words
// - full capacity updates only after near-full to first-threshold discharge
// - near-full window equals stored byte times two, in mAh
// - compensated threshold: no-load times factor minus load drop terms
// - adjust factor is low eleven bits, residual factor upper five
// - capacity term is 0, 3 percent, battery-low for the three thresholds
// - cold impedance factor applies only below 23 degrees Celsius
// - overload current threshold is a sixteen-bit mA value
// - midrange open-circuit thresholds are two's complement millivolts
// - self-discharge byte decoded; zero disables accumulation
// - light-load byte is leakage mA times 1024 over 45
// - above drop-off point, reduction rate per point is subtracted
// - base efficiency byte is ten times efficiency minus 74.5
// - reduction rate byte is percentage over 0.0125
// - temperature factor reduces efficiency per degree above 25 C
// - nickel applies all efficiency factors; Li-ion only base efficiency
// - charging voltage request reported and used for overvoltage base
// - overvoltage when pack exceeds charging voltage plus margin times 16
// - fast charge allowed: request the stored fast current
// - termination: zero request, then maintenance current when it ends
// - pack below final threshold: request pre-charge current
// - chemistry bit set selects Li-ion, clear selects nickel
// - compensation bit set selects computed thresholds, clear fixed
package charge_param_pkg;
  // ========================================================================
  // register map (word index == printed store location, byte address x4)
  localparam logic [7:0] ADDR_CHG_VOLT   = 8'h0A;
  localparam logic [7:0] ADDR_FAST_CUR   = 8'h1A;
  localparam logic [7:0] ADDR_MAINT_CUR  = 8'h1C;
  localparam logic [7:0] ADDR_PRE_CUR    = 8'h1E;
  localparam logic [7:0] ADDR_LIGHT_LOAD = 8'h2B;
  localparam logic [7:0] ADDR_PACK_CFG   = 8'h3F;
  localparam logic [7:0] ADDR_OVERLOAD   = 8'h46;
  localparam logic [7:0] ADDR_OV_MARGIN  = 8'h48;
  localparam logic [7:0] ADDR_BASE_EFF   = 8'h4D;
  localparam logic [7:0] ADDR_SELF_DIS   = 8'h53;
  localparam logic [7:0] ADDR_BATT_LOW   = 8'h54;
  localparam logic [7:0] ADDR_NEAR_FULL  = 8'h55;
  localparam logic [7:0] ADDR_EFF_TEMP   = 8'h63;
  localparam logic [7:0] ADDR_EFF_DROP   = 8'h64;
  localparam logic [7:0] ADDR_EFF_RATE   = 8'h65;
  localparam logic [7:0] ADDR_OPEN_CIRCUIT_QUARTER_VOLTAGE      = 8'h6C;
  localparam logic [7:0] ADDR_VOC50      = 8'h6E;
  localparam logic [7:0] ADDR_VOC75      = 8'h70;
  localparam logic [7:0] ADDR_FINAL_THR  = 8'h72;
  localparam logic [7:0] ADDR_EMF_MID    = 8'h74;
  localparam logic [7:0] ADDR_FIRST_THR  = 8'h78;
  localparam logic [7:0] ADDR_RATE_R     = 8'h7A;
  // own registers: live measurements in, computed results out
  localparam logic [7:0] ADDR_MEAS_VOLT  = 8'h80;
  localparam logic [7:0] ADDR_MEAS_CUR   = 8'h81;
  localparam logic [7:0] ADDR_MEAS_TEMP  = 8'h82;
  localparam logic [7:0] ADDR_MEAS_RELATIVE_CHARGE_STATE  = 8'h83;
  localparam logic [7:0] ADDR_CTRL       = 8'h84;
  localparam logic [7:0] ADDR_STATUS     = 8'h88;
  localparam logic [7:0] ADDR_THR_FINAL  = 8'h89;
  localparam logic [7:0] ADDR_THR_MID    = 8'h8A;
  localparam logic [7:0] ADDR_THR_FIRST  = 8'h8B;
  localparam logic [7:0] ADDR_CUR_REQ    = 8'h8C;
  localparam logic [7:0] ADDR_EFF_OUT    = 8'h8D;
  localparam logic [7:0] ADDR_NFW_OUT    = 8'h8E;

  // ========================================================================
  // field positions
  localparam int CFG_CHEMISTRY_SELECT_BIT = 2;
  localparam int CFG_THRESHOLD_COMPENSATION_ENABLE_BIT = 4;
  localparam int CFG_VCOR_BIT = 3;
  localparam int CTRL_FAST    = 0;
  localparam int CTRL_TERM    = 1;
  localparam int CTRL_SUSP    = 2;
  localparam int CTRL_NEARFUL = 3;
  localparam int CTRL_DISCH   = 4;
  localparam int ADJ_W        = 11;
  localparam int RES_W        = 5;

  // ========================================================================
  // scale figures, fixed point: efficiency in 0.0125 percent units
  localparam int  COLD_LIMIT_C   = 23;
  localparam int  EFF_REF_C      = 25;
  localparam int  MID_CAP_PCT    = 3;
  localparam int  EFF_BASE_UNITS = 5960;  // 74.5 percent / 0.0125
  localparam int  EFF_STEP_UNITS = 8;     // 0.1 percent / 0.0125
  localparam int  OVM_SHIFT      = 4;     // margin unit 16 mV
  localparam int  NFW_SHIFT      = 1;     // near-full unit 2 mAh
  localparam int  TEMP_DIV       = 16;    // tenth-degree byte over 1.6

  // msb first: field order matches the CTRL_* bit positions above
  typedef struct packed {
    logic       discharging;
    logic       near_full;
    logic       suspended;
    logic       terminated;
    logic       fast_allowed;
  } charge_ctrl_s;

  typedef struct packed {
    logic       overvoltage;
    logic       below_final;
    logic       below_first;
    logic       capacity_update;
    logic       self_dis_on;
    logic       voc_check_low;
  } charge_status_s;

  typedef enum logic [1:0] {
    REQ_ZERO, REQ_PRE, REQ_FAST, REQ_MAINT
  } cur_sel_e;

  typedef enum logic [1:0] {
    LEARN_IDLE, LEARN_ARMED, LEARN_DONE
  } learn_e;
endpackage

// ### verification/battery_charge_param_checker.sv
// port-level assertions for the charge parameter control block
module battery_charge_param_checker
  import charge_param_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic [7:0]        addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [DATA_W-1:0] charging_current_req,
  input wire logic [DATA_W-1:0] charging_voltage_req,
  input wire logic              overvoltage_suspend,
  input wire logic              capacity_update
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================================
  // shadow copies of stored words, so no body access is needed
  logic [DATA_W-1:0] meas, chg, fast, pre, thr0, thr2;
  logic [DATA_W+4:0] lim;
  logic [7:0]        marg, cfg;
  logic [4:0]        ctl;
  logic [2:0]        quiet;
  logic              settled, ov_exp, stop;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {meas, chg, fast, pre, thr0, thr2} <= '0;
      {marg, cfg, ctl} <= '0;
    end else if (wr) begin
      case (addr)
        ADDR_MEAS_VOLT: meas <= wdata;
        ADDR_CHG_VOLT:  chg <= wdata;
        ADDR_FAST_CUR:  fast <= wdata;
        ADDR_PRE_CUR:   pre <= wdata;
        ADDR_FINAL_THR: thr0 <= wdata;
        ADDR_FIRST_THR: thr2 <= wdata;
        ADDR_OV_MARGIN: marg <= wdata[7:0];
        ADDR_PACK_CFG:  cfg <= wdata[7:0];
        ADDR_CTRL:      ctl <= wdata[4:0];
        default: ;
      endcase
    end
  end
  // derived outputs trail a write by a few cycles; judge only when quiet
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) quiet <= '0;
    else if (wr) quiet <= '0;
    else if (quiet != 3'h7) quiet <= quiet + 3'h1;
  end
  assign settled = quiet >= 3'h5;
  assign lim = {5'h00, chg} + {{(DATA_W-7){1'b0}}, marg, 4'h0};
  assign ov_exp = {5'h00, meas} > lim;
  assign stop = ctl[CTRL_TERM] | ctl[CTRL_SUSP];
  // ==========================================================================
  // assertions
  a_volt_req_load : assert property (
    wr && addr == ADDR_CHG_VOLT |-> ##2 charging_voltage_req == $past(wdata, 2))
    else $error("voltage request did not follow the stored word");
  a_volt_req_hold : assert property (
    $changed(charging_voltage_req) |->
      $past(wr, 2) && $past(addr, 2) == ADDR_CHG_VOLT)
    else $error("voltage request changed without a write");
  a_ov_level : assert property (
    settled |-> overvoltage_suspend == ov_exp)
    else $error("overvoltage flag disagrees with margin compare");
  a_ov_zero_req : assert property (
    $rose(overvoltage_suspend) |-> ##[0:2] charging_current_req == '0)
    else $error("overvoltage did not zero the current request");
  a_stop_zero_req : assert property (
    settled && stop |-> charging_current_req == '0)
    else $error("current request not zero while stopped");
  a_fast_current : assert property (
    settled && ctl == 5'h01 && !ov_exp && !cfg[CFG_THRESHOLD_COMPENSATION_ENABLE_BIT] && meas >= thr0
      |-> charging_current_req == fast)
    else $error("fast current not requested");
  a_pre_current : assert property (
    settled && !stop && !ov_exp && !cfg[CFG_THRESHOLD_COMPENSATION_ENABLE_BIT] && meas < thr0
      |-> charging_current_req == pre)
    else $error("pre-charge current not requested");
  a_learn_single : assert property (
    capacity_update |=> !capacity_update)
    else $error("capacity update longer than one cycle");
  a_learn_qualified : assert property (
    capacity_update && !cfg[CFG_THRESHOLD_COMPENSATION_ENABLE_BIT] |-> meas < thr2 && ctl[CTRL_DISCH])
    else $error("capacity update without qualified discharge");
endmodule // battery_charge_param_checker

bind battery_charge_param_control battery_charge_param_checker #(
  .DATA_W(DATA_W)
) i_battery_charge_param_checker (
  .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .charging_current_req(charging_current_req),
  .charging_voltage_req(charging_voltage_req),
  .overvoltage_suspend(overvoltage_suspend),
  .capacity_update(capacity_update)
);

// ### verification/charger_model.sv
// smart charger model that takes the pack's current and voltage requests
module charger_model (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [15:0] charging_current_req,
  input  wire logic [15:0] charging_voltage_req,
  output logic      [15:0] applied_current,
  output logic      [15:0] applied_voltage
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // charger polls the requests; one cycle of reaction time
  // applies requests
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      applied_current <= '0;
      applied_voltage <= '0;
    end else begin
      applied_current <= charging_current_req;
      applied_voltage <= charging_voltage_req;
    end
  end
endmodule // charger_model

// ### verification/battery_charge_param_control_tb.sv
// self-checking bench for the charge parameter control block
module battery_charge_param_control_tb
  import charge_param_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_b, wr, rd, ov, learn;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, cur_req, volt_req, seen_cur, seen_volt, v;
  int          n_mismatch, cmp_count, k;
  // Li-ion, fixed thresholds, battery low eighteen percent
  localparam logic [7:0] CFG_A [18] = '{ADDR_PACK_CFG, ADDR_MEAS_VOLT,
    ADDR_MEAS_TEMP, ADDR_MEAS_RELATIVE_CHARGE_STATE, ADDR_FINAL_THR, ADDR_EMF_MID,
    ADDR_FIRST_THR, ADDR_BATT_LOW, ADDR_NEAR_FULL, ADDR_CHG_VOLT,
    ADDR_OV_MARGIN, ADDR_FAST_CUR, ADDR_MAINT_CUR, ADDR_PRE_CUR,
    ADDR_BASE_EFF, ADDR_EFF_TEMP, ADDR_EFF_DROP, ADDR_EFF_RATE};
  localparam logic [15:0] CFG_D [18] = '{16'h0004, 16'h2EE0, 16'h0019,
    16'h0064, 16'h251C, 16'h2710, 16'h2904, 16'h0012, 16'h0064, 16'h3138,
    16'h0032, 16'h0BB8, 16'h0064, 16'h012C, 16'h00E1, 16'h0020, 16'h00A0,
    16'h0050};
  localparam logic [15:0] CUR_C [6] = '{16'h0001, 16'h0003, 16'h0000,
    16'h0001, 16'h0003, 16'h0005};
  localparam logic [15:0] CUR_V [6] = '{16'h2EE0, 16'h2EE0, 16'h2EE0,
    16'h2328, 16'h2328, 16'h2EE0};
  localparam logic [15:0] CUR_E [6] = '{16'h0BB8, 16'h0000, 16'h0064,
    16'h012C, 16'h0000, 16'h0000};
  localparam logic [15:0] EFF_C [5] = '{16'h0004, 16'h0000, 16'h0000,
    16'h0000, 16'h0004};
  localparam logic [15:0] EFF_R [5] = '{16'h0064, 16'h005F, 16'h0064,
    16'h005F, 16'h0064};
  localparam logic [15:0] EFF_T [5] = '{16'h0019, 16'h0019, 16'h0019,
    16'h001B, 16'h001B};
  localparam logic [15:0] EFF_E [5] = '{16'h1E50, 16'h1E50, 16'h1D10,
    16'h1E28, 16'h1E50};

  battery_charge_param_control #(.DATA_W(16)) i_battery_charge_param_control (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .charging_current_req(cur_req),
    .charging_voltage_req(volt_req), .overvoltage_suspend(ov),
    .capacity_update(learn));
  charger_model i_charger_model (
    .clk(clk), .rst_b(rst_b), .charging_current_req(cur_req),
    .charging_voltage_req(volt_req), .applied_current(seen_cur),
    .applied_voltage(seen_volt));

  always #2 clk = ~clk;
  // ==========================================================================
  // access tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task automatic put(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic expect_reg(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 v = rdata;
    check(v, e);
  endtask
  // derived outputs lag a write by up to four cycles
  task automatic settle;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic count_learn(input int cycles);
    k = 0;
    repeat (cycles) begin
      @(posedge clk);
      #1;
      if (learn === 1'b1) k++;
    end
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    {clk, rst_b, wr, rd, addr, wdata} = '0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 18; i++) put(CFG_A[i], CFG_D[i]);
    settle;
    expect_reg(ADDR_THR_FINAL, 16'h251C);
    expect_reg(ADDR_THR_MID, 16'h2710);
    expect_reg(ADDR_THR_FIRST, 16'h2904);
    expect_reg(ADDR_NFW_OUT, 16'h00C8);
    check(volt_req, 16'h3138);
    check(seen_volt, 16'h3138);
    for (int i = 0; i < 6; i++) begin
      put(ADDR_CTRL, CUR_C[i]);
      put(ADDR_MEAS_VOLT, CUR_V[i]);
      settle;
      check(seen_cur, CUR_E[i]);
      expect_reg(ADDR_CUR_REQ, CUR_E[i]);
    end
    put(ADDR_CTRL, 16'h0001);
    put(ADDR_MEAS_VOLT, 16'h3458);
    settle;
    check({15'h0000, ov}, 16'h0000);
    check(cur_req, 16'h0BB8);
    put(ADDR_MEAS_VOLT, 16'h3459);
    settle;
    check({15'h0000, ov}, 16'h0001);
    check(cur_req, 16'h0000);
    expect_reg(ADDR_STATUS, 16'h0020);
    put(ADDR_MEAS_VOLT, 16'h2EE0);
    for (int i = 0; i < 5; i++) begin
      put(ADDR_PACK_CFG, EFF_C[i]);
      put(ADDR_MEAS_RELATIVE_CHARGE_STATE, EFF_R[i]);
      put(ADDR_MEAS_TEMP, EFF_T[i]);
      settle;
      expect_reg(ADDR_EFF_OUT, EFF_E[i]);
    end
    for (int i = 0; i < 2; i++) begin
      put(ADDR_SELF_DIS, i ? 16'h00CB : 16'h0000);
      settle;
      expect_reg(ADDR_STATUS, i ? 16'h0002 : 16'h0000);
    end
    // midrange check on: pack below the decoded upper open-circuit mark
    put(ADDR_OVERLOAD, 16'h1770);
    put(ADDR_LIGHT_LOAD, 16'h0017);
    put(ADDR_VOC75, 16'hCB44);
    put(ADDR_PACK_CFG, 16'h000C);
    settle;
    expect_reg(ADDR_OVERLOAD, 16'h1770);
    expect_reg(ADDR_LIGHT_LOAD, 16'h0017);
    expect_reg(ADDR_STATUS, 16'h0003);
    expect_reg(ADDR_PACK_CFG, 16'h000C);
    // a drop without the near-full mark must not learn
    put(ADDR_CTRL, 16'h0010);
    put(ADDR_MEAS_VOLT, 16'h28A0);
    count_learn(12);
    check(16'(k), 16'h0000);
    put(ADDR_MEAS_VOLT, 16'h2EE0);
    put(ADDR_CTRL, 16'h0018);
    settle;
    put(ADDR_MEAS_VOLT, 16'h28A0);
    count_learn(20);
    check(16'(k), 16'h0001);
    expect_reg(8'hFF, 16'h0000);
    report_and_stop;
  end
endmodule // battery_charge_param_control_tb
